// [verilog/lhcf_pkg.sv]
// Package for the limp-home clock failover block.
// Assumes a single 25 MHz clock domain; no other dependencies.
package lhcf_pkg;
	localparam int LHCF_CNT_W = 13;
	localparam logic [12:0] LHCF_MID_CNT = 13'h1000;
	localparam logic [12:0] LHCF_LAST_CNT = 13'h1fff;
	localparam int LHCF_PERIOD = 8192;
	localparam int LHCF_CLK_MHZ = 25;
	localparam int LHCF_DIV = 1;
	localparam int LHCF_SYNC_W = 2;
	typedef enum logic [1:0] {
		LHCF_POR,
		LHCF_NORMAL,
		LHCF_LIMP,
		LHCF_CM_RESET
	} lhcf_state_e;
endpackage

// [verilog/lhcf_sync.sv]
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes clock and asynchronous active-high reset.
`timescale 1ns/10ps
module lhcf_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// [verilog/lhcf_counter.sv]
// Free-running 13-stage counter with a mid-count pulse.
// Assumes a one-cycle advance enable from the slow-clock divider.
`timescale 1ns/10ps
module lhcf_counter
	import lhcf_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control
	input wire logic tick,
	input wire logic clear,
	// Status
	output logic [LHCF_CNT_W-1:0] count,
	output logic mid_pulse
);
	wire [LHCF_CNT_W-1:0] next_count;

	assign next_count = count + 13'h0001;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
			mid_pulse <= 1'b0;
		end else begin
			mid_pulse <= tick && !clear && (next_count == LHCF_MID_CNT);
			if (clear) begin
				count <= '0;
			end else if (tick) begin
				count <= next_count;
			end
		end
	end
endmodule

// [verilog/lhcf_top.sv]
// Limp-home clock failover control: monitor polling, limp-home entry
// and exit, forced clock controls, flags, and power-on reset sequencing.
// Assumes clock_monitor_ok comes from the monitor on another clock,
// and that software bits are stable levels on this clock.
`timescale 1ns/10ps
module lhcf_top
	import lhcf_pkg::*;
#(
	parameter int SLOW_DIV = LHCF_DIV
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// External clock monitor and supply (asynchronous)
	input wire logic clock_monitor_ok,
	input wire logic pll_supply,
	input wire logic normal_mode,
	// PLL lock detector
	input wire logic pll_in_lock_window,
	// Software control bits
	input wire logic limp_home_disable,
	input wire logic clk_monitor_enable,
	input wire logic forced_clk_monitor_enable,
	input wire logic limp_home_irq_enable,
	input wire logic limp_home_irq_clear,
	input wire logic sw_bus_clk_from_pll,
	input wire logic sw_module_clk_select,
	input wire logic sw_pll_power_on,
	input wire logic auto_bandwidth,
	// Clock controls
	output logic pll_power_on,
	output logic bus_clk_from_pll,
	output logic module_clk_select,
	output logic clocks_forced_min,
	output logic monitor_active,
	output logic pll_ramp_relock,
	output logic pll_tracking,
	// Status and reset
	output logic limp_home_active_flag,
	output logic limp_home_irq_flag,
	output logic limp_home_irq,
	output logic internal_reset,
	output logic clk_monitor_reset,
	output logic reset_defaults
);
	lhcf_state_e state_q, state_d;
	logic [1:0] async_s;
	logic [15:0] div_q;
	logic tick;
	logic [LHCF_CNT_W-1:0] count;
	logic mid_pulse;
	logic limp_q, limp_d;
	logic limp_home_irq_flag_q;
	logic saved_bus_clk_from_pll_q, saved_mcs_q, saved_auto_q;
	logic cm_latch_q;
	logic por_limp_ok_q;

	wire ext_clk_ok;
	wire supply_ok;
	wire mon_enabled;
	wire loss_event;
	wire in_reset;
	wire leave_limp;
	wire enter_limp;
	wire cnt_clear;
	wire limp_change;

	lhcf_sync #(.WIDTH(2)) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.din({clock_monitor_ok, pll_supply}),
		.dout(async_s)
	);

	lhcf_counter u_cnt (
		.clock(clock),
		.sys_rst(sys_rst),
		.tick(tick),
		.clear(cnt_clear),
		.count(count),
		.mid_pulse(mid_pulse)
	);

	// Slow-clock divider
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= '0;
		end else if (tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	assign tick = (div_q == 16'(SLOW_DIV - 1));

	// Decoding
	assign ext_clk_ok = async_s[1];
	assign supply_ok = async_s[0];
	assign mon_enabled = clk_monitor_enable || forced_clk_monitor_enable;
	assign loss_event = (state_q == LHCF_NORMAL) && mon_enabled && !ext_clk_ok;
	assign in_reset = (state_q == LHCF_POR) || (state_q == LHCF_CM_RESET);
	// Exit check only at mid-count
	assign leave_limp = limp_q && mid_pulse && ext_clk_ok;
	assign enter_limp = loss_event && !limp_home_disable && supply_ok;
	assign cnt_clear = (state_q == LHCF_POR) && mid_pulse && !limp_q;
	assign limp_change = limp_d != limp_q;

	// State sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			LHCF_POR: begin
				if (mid_pulse) begin
					if (limp_d) begin
						state_d = LHCF_LIMP;
					end else if (supply_ok || ext_clk_ok) begin
						state_d = LHCF_NORMAL;
					end
				end
			end
			LHCF_NORMAL: begin
				if (loss_event && (limp_home_disable || !supply_ok)) begin
					state_d = LHCF_CM_RESET;
				end
			end
			LHCF_LIMP: begin
				if (leave_limp) begin
					state_d = LHCF_NORMAL;
				end
			end
			LHCF_CM_RESET: begin
				if (ext_clk_ok) begin
					state_d = LHCF_NORMAL;
				end
			end
		endcase
		if (state_q == LHCF_NORMAL && enter_limp) begin
			state_d = LHCF_LIMP;
		end
	end

	// Limp-home condition
	always_comb begin
		limp_d = limp_q;
		if (state_q == LHCF_POR) begin
			limp_d = supply_ok && por_limp_ok_q && !ext_clk_ok;
		end else if (enter_limp) begin
			limp_d = 1'b1;
		end else if (leave_limp) begin
			limp_d = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= LHCF_POR;
			limp_q <= 1'b0;
			por_limp_ok_q <= 1'b0;
		end else begin
			state_q <= state_d;
			limp_q <= limp_d;
			por_limp_ok_q <= normal_mode;
		end
	end

	// Clock-monitor reset latch
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cm_latch_q <= 1'b0;
		end else if (state_d == LHCF_CM_RESET) begin
			cm_latch_q <= 1'b1;
		end else if (state_q == LHCF_CM_RESET) begin
			cm_latch_q <= 1'b0;
		end
	end

	// Saved selects before the loss; bus-clock select also tracks software in limp-home
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			saved_bus_clk_from_pll_q <= 1'b0;
			saved_mcs_q <= 1'b0;
			saved_auto_q <= 1'b0;
		end else if (!limp_q) begin
			saved_bus_clk_from_pll_q <= sw_bus_clk_from_pll;
			saved_mcs_q <= sw_module_clk_select;
			saved_auto_q <= auto_bandwidth;
		end else begin
			saved_bus_clk_from_pll_q <= sw_bus_clk_from_pll;
		end
	end

	// Interrupt flag, set wins over clear
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			limp_home_irq_flag_q <= 1'b0;
		end else if (limp_change) begin
			limp_home_irq_flag_q <= 1'b1;
		end else if (limp_home_irq_clear) begin
			limp_home_irq_flag_q <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pll_power_on <= 1'b1;
			bus_clk_from_pll <= 1'b0;
			module_clk_select <= 1'b0;
			clocks_forced_min <= 1'b0;
			monitor_active <= 1'b1;
			pll_ramp_relock <= 1'b0;
			pll_tracking <= 1'b0;
			limp_home_active_flag <= 1'b0;
			limp_home_irq_flag <= 1'b0;
			limp_home_irq <= 1'b0;
			internal_reset <= 1'b1;
			clk_monitor_reset <= 1'b0;
			reset_defaults <= 1'b1;
		end else begin
			pll_power_on <= limp_d || sw_pll_power_on;
			bus_clk_from_pll <= limp_d ? 1'b1 : (limp_q ? saved_bus_clk_from_pll_q : sw_bus_clk_from_pll);
			module_clk_select <= limp_d ? 1'b0 : (limp_q ? saved_mcs_q : sw_module_clk_select);
			clocks_forced_min <= limp_d;
			monitor_active <= limp_d || mon_enabled;
			pll_ramp_relock <= leave_limp && saved_auto_q && saved_bus_clk_from_pll_q;
			pll_tracking <= auto_bandwidth ? pll_in_lock_window : 1'b0;
			limp_home_active_flag <= limp_d;
			limp_home_irq_flag <= limp_change || (limp_home_irq_flag_q && !limp_home_irq_clear);
			limp_home_irq <= (limp_change || (limp_home_irq_flag_q && !limp_home_irq_clear))
				&& limp_home_irq_enable;
			internal_reset <= (state_d == LHCF_POR) || (state_d == LHCF_CM_RESET);
			clk_monitor_reset <= cm_latch_q || (state_d == LHCF_CM_RESET);
			reset_defaults <= in_reset && supply_ok;
		end
	end

	// Assertions
	sequence s_loss_nolimp;
		(state_q == LHCF_NORMAL) && mon_enabled && !ext_clk_ok && limp_home_disable;
	endsequence

	a_cm_reset_entry: assert property (@(posedge clock) disable iff (sys_rst)
		s_loss_nolimp |=> (state_q == LHCF_CM_RESET) ##1 clk_monitor_reset)
		else $error("clock loss without limp-home did not reset");

	a_limp_forces: assert property (@(posedge clock) disable iff (sys_rst)
		limp_q && !leave_limp |=> pll_power_on && bus_clk_from_pll && !module_clk_select)
		else $error("limp-home controls not forced");

	a_flag_tracks: assert property (@(posedge clock) disable iff (sys_rst)
		##1 limp_home_active_flag == $past(limp_d))
		else $error("limp-home flag does not follow state");

	a_irq_on_change: assert property (@(posedge clock) disable iff (sys_rst)
		$changed(limp_home_active_flag) |-> limp_home_irq_flag)
		else $error("flag change did not set interrupt flag");

	a_monitor_forced: assert property (@(posedge clock) disable iff (sys_rst)
		limp_q && limp_d |=> monitor_active)
		else $error("monitor not active in limp-home");

	a_exit_midcount: assert property (@(posedge clock) disable iff (sys_rst)
		$fell(limp_q) && (state_q != LHCF_POR) |-> $past(mid_pulse))
		else $error("limp-home left outside mid-count");

	a_irq_gated: assert property (@(posedge clock) disable iff (sys_rst)
		limp_home_irq |-> limp_home_irq_flag && $past(limp_home_irq_enable))
		else $error("interrupt without flag and enable");

	a_por_release: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == LHCF_POR) && !mid_pulse |=> internal_reset)
		else $error("internal reset released early");

	a_cm_latch_hold: assert property (@(posedge clock) disable iff (sys_rst)
		(state_q == LHCF_CM_RESET) && !ext_clk_ok |=> (state_q == LHCF_CM_RESET) && !limp_q)
		else $error("clock-monitor reset left without clock");
endmodule

// [verification/lhcf_osc_model.sv]
// Far-side model: external clock presence and PLL lock window.
// Assumes the bench commands oscillator presence with ext_on.
`timescale 1ns/10ps
module lhcf_osc_model #(
	parameter int LOCK_CYC = 16
) (
	// Clock and command
	input wire logic clock,
	input wire logic ext_on,
	input wire logic pll_power_on,
	// Far-side outputs
	output logic clock_monitor_ok,
	output logic pll_in_lock_window
);
	int lock_q = 0;
	initial clock_monitor_ok = 1'b0;
	initial pll_in_lock_window = 1'b0;
	// Lock window only after the PLL has run a while
	always @(posedge clock) begin
		clock_monitor_ok <= ext_on;
		lock_q <= pll_power_on ? ((lock_q < LOCK_CYC) ? lock_q + 1 : lock_q) : 0;
		pll_in_lock_window <= pll_power_on && (lock_q == LOCK_CYC);
	end
endmodule

// [verification/lhcf_top_tb.sv]
// Self-checking bench for the limp-home clock failover block.
// Assumes SLOW_DIV of 1, so one counter tick per clock.
`timescale 1ns/10ps
module lhcf_top_tb;
	localparam int MID = int'(lhcf_pkg::LHCF_MID_CNT);
	logic clock = 0, sys_rst = 1, ext_on = 0, pll_supply = 1, normal_mode = 1;
	logic limp_home_disable = 0, clk_monitor_enable = 0, forced_clk_monitor_enable = 0;
	logic limp_home_irq_enable = 0, limp_home_irq_clear = 0, auto_bandwidth = 0;
	logic sw_bus_clk_from_pll = 0, sw_module_clk_select = 1, sw_pll_power_on = 1;
	logic clock_monitor_ok, pll_in_lock_window, pll_power_on, bus_clk_from_pll;
	logic module_clk_select, clocks_forced_min, monitor_active, pll_ramp_relock;
	logic pll_tracking, limp_home_active_flag, limp_home_irq_flag, limp_home_irq;
	logic internal_reset, clk_monitor_reset, reset_defaults;
	logic ramp_seen = 0;
	int fail_count = 0;
	int check_count = 0;
	always #20 clock = ~clock;
	always @(posedge clock) if (pll_ramp_relock === 1'b1) ramp_seen <= 1'b1;
	lhcf_osc_model i_osc (.clock, .ext_on, .pll_power_on, .clock_monitor_ok,
		.pll_in_lock_window);
	lhcf_top #(.SLOW_DIV(1)) i_dut (.clock, .sys_rst, .clock_monitor_ok, .pll_supply,
		.normal_mode, .pll_in_lock_window, .limp_home_disable, .clk_monitor_enable,
		.forced_clk_monitor_enable, .limp_home_irq_enable, .limp_home_irq_clear,
		.sw_bus_clk_from_pll, .sw_module_clk_select, .sw_pll_power_on, .auto_bandwidth,
		.pll_power_on, .bus_clk_from_pll, .module_clk_select, .clocks_forced_min,
		.monitor_active, .pll_ramp_relock, .pll_tracking, .limp_home_active_flag,
		.limp_home_irq_flag, .limp_home_irq, .internal_reset, .clk_monitor_reset,
		.reset_defaults);
	task automatic stop_test;
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic e, input logic s);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_for(ref logic s, input logic v, input int n, input string nm);
		for (int i = 0; i < n && s !== v; i++) cyc(1);
		chk(nm, v, s);
	endtask
	task automatic irq_clr;
		@(posedge clock) limp_home_irq_clear <= 1'b1;
		@(posedge clock) limp_home_irq_clear <= 1'b0;
		cyc(3);
	endtask
	task automatic do_reset;
		@(posedge clock) sys_rst <= 1'b1;
		cyc(6);
		@(posedge clock) sys_rst <= 1'b0;
	endtask
	initial begin
		repeat (70000) @(posedge clock);
		fail_count++;
		stop_test();
	end
	initial begin
		cyc(6);
		chk("reset_defaults", 1'b1, reset_defaults);
		chk("pll_power_on", 1'b1, pll_power_on);
		chk("monitor_active", 1'b1, monitor_active);
		@(posedge clock) sys_rst <= 1'b0;
		cyc(MID - 8);
		chk("internal_reset", 1'b1, internal_reset);
		wait_for(internal_reset, 1'b0, 16, "internal_reset");
		chk("limp_home_active_flag", 1'b1, limp_home_active_flag);
		chk("limp_home_irq_flag", 1'b1, limp_home_irq_flag);
		chk("bus_clk_from_pll", 1'b1, bus_clk_from_pll);
		chk("module_clk_select", 1'b0, module_clk_select);
		chk("clocks_forced_min", 1'b1, clocks_forced_min);
		chk("monitor_active", 1'b1, monitor_active);
		irq_clr();
		chk("limp_home_irq_flag", 1'b0, limp_home_irq_flag);
		@(posedge clock) limp_home_irq_enable <= 1'b1;
		@(posedge clock) ext_on <= 1'b1;
		cyc(8140);
		chk("limp_home_active_flag", 1'b1, limp_home_active_flag);
		wait_for(limp_home_active_flag, 1'b0, 120, "limp_home_active_flag");
		cyc(2);
		chk("limp_home_irq_flag", 1'b1, limp_home_irq_flag);
		chk("limp_home_irq", 1'b1, limp_home_irq);
		chk("bus_clk_from_pll", 1'b0, bus_clk_from_pll);
		chk("module_clk_select", 1'b1, module_clk_select);
		chk("clocks_forced_min", 1'b0, clocks_forced_min);
		chk("monitor_active", 1'b0, monitor_active);
		chk("pll_tracking", 1'b0, pll_tracking);
		chk("ramp_seen", 1'b0, ramp_seen);
		@(posedge clock) auto_bandwidth <= 1'b1;
		sw_bus_clk_from_pll <= 1'b1;
		clk_monitor_enable <= 1'b1;
		cyc(40);
		chk("pll_tracking", 1'b1, pll_tracking);
		irq_clr();
		@(posedge clock) ext_on <= 1'b0;
		sw_pll_power_on <= 1'b0;
		wait_for(limp_home_active_flag, 1'b1, 8, "limp_home_active_flag");
		cyc(1);
		chk("limp_home_irq", 1'b1, limp_home_irq);
		chk("pll_power_on", 1'b1, pll_power_on);
		chk("clk_monitor_reset", 1'b0, clk_monitor_reset);
		@(posedge clock) ext_on <= 1'b1;
		wait_for(limp_home_active_flag, 1'b0, 8300, "limp_home_active_flag");
		cyc(3);
		chk("ramp_seen", 1'b1, ramp_seen);
		chk("pll_power_on", 1'b0, pll_power_on);
		@(posedge clock) limp_home_disable <= 1'b1;
		clk_monitor_enable <= 1'b0;
		forced_clk_monitor_enable <= 1'b1;
		cyc(4);
		@(posedge clock) ext_on <= 1'b0;
		wait_for(clk_monitor_reset, 1'b1, 8, "clk_monitor_reset");
		cyc(20);
		chk("internal_reset", 1'b1, internal_reset);
		chk("limp_home_active_flag", 1'b0, limp_home_active_flag);
		@(posedge clock) ext_on <= 1'b1;
		wait_for(internal_reset, 1'b0, 12400, "internal_reset");
		chk("limp_home_active_flag", 1'b0, limp_home_active_flag);
		@(posedge clock) forced_clk_monitor_enable <= 1'b0;
		@(posedge clock) ext_on <= 1'b0;
		cyc(20);
		chk("clk_monitor_reset", 1'b0, clk_monitor_reset);
		normal_mode <= 1'b0;
		do_reset();
		cyc(MID + 40);
		chk("limp_home_active_flag", 1'b0, limp_home_active_flag);
		pll_supply <= 1'b0;
		normal_mode <= 1'b1;
		do_reset();
		cyc(MID + 40);
		chk("internal_reset", 1'b1, internal_reset);
		chk("limp_home_active_flag", 1'b0, limp_home_active_flag);
		@(posedge clock) ext_on <= 1'b1;
		wait_for(internal_reset, 1'b0, 12400, "internal_reset");
		stop_test();
	end
endmodule
